// ===== design/bsse_map.svh
`ifndef BSSE_MAP_SVH
`define BSSE_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave.
// ----------------------------------------------------------------------------
`define BSSE_OFF_INSTR   8'h00
`define BSSE_OFF_STATUS  8'h04
`define BSSE_OFF_PC      8'h08
`define BSSE_OFF_MAR     8'h0c
`define BSSE_OFF_AR1     8'h10
`define BSSE_OFF_AR4     8'h1c

// ----------------------------------------------------------------------------
// Status register fields and bus responses.
// ----------------------------------------------------------------------------
`define BSSE_ST_BUSY     0
`define BSSE_ST_SHERR    1
`define BSSE_ST_ILLOP    2
`define BSSE_ST_SENSE_LO 8
`define BSSE_RESP_OKAY   2'h0
`define BSSE_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------------
// Opcodes (two octal digits in a six-bit field).
// ----------------------------------------------------------------------------
`define BSSE_OP_JUMP     6'h06
`define BSSE_OP_JSAVE    6'h07
`define BSSE_OP_BRANCH   6'h30
`define BSSE_OP_FCLR     6'h31
`define BSSE_OP_FSET     6'h32
`define BSSE_OP_SHR      6'h20
`define BSSE_OP_SHL      6'h21

// ----------------------------------------------------------------------------
// Field codes, word layout and cycle counts.
// ----------------------------------------------------------------------------
`define BSSE_FLD_PC      4'h1
`define BSSE_FLD_MAR     4'h2
`define BSSE_FLD_CH_LO   4'h3
`define BSSE_FLD_SIGN_HI 4'h4
`define BSSE_FLD_LOW     4'h5
`define BSSE_FLD_EQUAL   4'h6
`define BSSE_FLD_HIGH    4'h7
`define BSSE_SIGN_BIT    24
`define BSSE_DIGIT_FILL  4'h3
`define BSSE_DIGITS_WORD 6
`define BSSE_CYC_JUMP    4'h1
`define BSSE_CYC_JSAVE   4'h3
`define BSSE_CYC_FLAG    4'h2
`define BSSE_CYC_TAKEN   4'h1
`define BSSE_CYC_NOTAKEN 4'h2
`define BSSE_CYC_SHR1    4'h4
`define BSSE_CYC_SHR2    4'h7
`define BSSE_CYC_SHL1    4'h3
`define BSSE_CYC_SHL2    4'h6
`define BSSE_LONG_LO     15'h0007
`define BSSE_LONG_HI     15'h000c

`endif

// ===== design/bsse_pkg.sv
package bsse_pkg;

	// ------------------------------------------------------------------------
	// Instruction word, most significant bit first.
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic       ind;
		logic [3:0] idx;
		logic [5:0] op;
		logic [3:0] fld;
		logic [9:0] addr;
	} bsse_instr_t;

	// Core memory request and answer.
	typedef struct packed {
		logic        valid;
		logic        we;
		logic [14:0] addr;
		logic [24:0] wdata;
	} bsse_mem_req_t;

	typedef struct packed {
		logic        ready;
		logic [24:0] rdata;
	} bsse_mem_rsp_t;

	// Thirteen channel address counters.
	typedef logic [12:0][14:0] bsse_chan_t;

	// Sequencer states.
	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_ADDR  = 5'h02,
		S_IND   = 5'h04,
		S_EXEC  = 5'h08,
		S_STORE = 5'h10
	} bsse_state_t;

endpackage

// ===== design/bsse_digit_fix.sv
`timescale 1ns/10ps
`include "bsse_map.svh"

// Replaces each non-numeric digit code of a two-word operand by decimal zero.
module bsse_digit_fix
	import bsse_pkg::*;
(
	input  wire logic [47:0] digits_in,
	output logic      [47:0] digits_out
);

	// ------------------------------------------------------------------------
	// Digit conversion.
	// ------------------------------------------------------------------------
	// Valid codes run from 0011 to 1100; anything else becomes 0011.
	always_comb
	begin
		for (int i = 0; i < 12; i++)
		begin
			if (digits_in[i*4 +: 4] < 4'h3 || digits_in[i*4 +: 4] > 4'hc)
				digits_out[i*4 +: 4] = `BSSE_DIGIT_FILL;
			else
				digits_out[i*4 +: 4] = digits_in[i*4 +: 4];
		end
	end

endmodule // bsse_digit_fix

// ===== design/bsse_exec.sv
// Behaviour
// - Sign-branch field codes 0001 to 0100 pick the sign of registers one to four.
// - Testing a sign or sense indicator never changes that indicator.
// - Opcode 06 loads the counter with the indexed address in one cycle.
// - Opcode 07 stores counter plus one, then jumps to address plus one; three cycles.
// - The stored word from opcode 07 has bits 15 to 24 cleared.
// - Field 0001 picks the program counter, 0011 to 1111 the channel counters.
// - Field 0010 stores the memory-address register plus one instead.
// - Opcode 62 sets the selected sense indicator in two cycles.
// - Field codes 1000 to 1111 map onto sense indicators one to eight.
// - Setting an indicator already set is harmless and leaves it set.
// - Opcode 61 clears the selected sense indicator in two cycles.
// - Clearing an indicator already clear is harmless and leaves it clear.
// - Opcode 60 jumps in one cycle if the flag is set, else advances in two.
// - Shift count is the indexed, optionally indirect address; index 0000 adds nothing.
// - Shifts span at most two registers; other registers are untouched.
// - Right shift takes 4 or 7 cycles; two words by 7 to 12 take 4.
// - Right shift keeps signs, drops low digits, fills 0011 from the top.
// - Left shift takes 3 or 6 cycles; two words by 7 to 12 take 3.
// - Left shift keeps signs, drops high digits, fills 0011 from the bottom.
// - Count zero only fixes bad digits; count beyond size clears the operand.
// - Shifts honour indirect addressing and take their registers from the field code.
// - Sign branch jumps when positive, advances to the next when negative.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "bsse_map.svh"

module bsse_exec
	import bsse_pkg::*;
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic [3:0]         idx_sel,
	input  wire logic [14:0]   idx_val,
	input  wire bsse_chan_t    channel_address_counter,
	input  wire logic [2:0]    cmp_ind,
	output bsse_mem_req_t      mem_req,
	input  wire bsse_mem_rsp_t mem_rsp
);

	// ------------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------------
	bsse_state_t  state_ff;
	bsse_instr_t  instr_ff;
	logic [14:0]  ea_ff;
	logic [3:0]   cnt_ff;
	logic [14:0]  program_counter_ff;
	logic [14:0]  mar_ff;
	logic [24:0]  ar_ff [4];
	logic [7:0]   sense_ff;
	logic         sherr_ff;
	logic         illop_ff;
	logic [7:0]   awaddr_ff;
	logic         aw_have_ff;
	logic [31:0]  wdata_ff;
	logic [3:0]   wstrb_ff;
	logic         w_have_ff;
	logic         bvalid_ff;
	logic [1:0]   bresp_ff;
	logic         rvalid_ff;
	logic [31:0]  rdata_ff;
	logic [1:0]   rresp_ff;
	logic [14:0]  nxt_ea;
	logic [3:0]   nxt_cnt;
	logic         take_jump;
	logic         two_word;
	logic [47:0]  operand;
	logic [47:0]  fixed;
	logic [47:0]  shifted;
	logic [14:0]  save_val;
	logic         wr_fire;
	logic         rd_fire;
	logic         done;
	logic         busy;

	// ------------------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------------------
	// Merges a bus write into a register word under the byte strobes.
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[b*8 +: 8] = data[b*8 +: 8];
		end
		return r;
	endfunction

	// Decimal shift over six or twelve digits with 0011 fill.
	function automatic logic [47:0] dshift(input logic [47:0] d, input logic [14:0] n,
		input logic left, input logic two);
		logic [47:0] r;
		int          size;
		int          k;
		int          src;
		r = {12{`BSSE_DIGIT_FILL}};
		size = two ? 2 * `BSSE_DIGITS_WORD : `BSSE_DIGITS_WORD;
		k = (int'(n) > size) ? size : int'(n);
		for (int i = 0; i < 12; i++)
		begin
			src = left ? i - k : i + k;
			if (i < size && src >= 0 && src < size)
				r[i*4 +: 4] = d[src*4 +: 4];
		end
		return r;
	endfunction

	// ------------------------------------------------------------------------
	// Instruction decode.
	// ------------------------------------------------------------------------
	assign busy    = (state_ff != S_IDLE);
	assign idx_sel = instr_ff.idx;
	// Index designation 0000 leaves the address or count as written.
	assign nxt_ea = {5'h00, instr_ff.addr} + ((instr_ff.idx == 4'h0) ? 15'h0000 : idx_val);
	// Two words when the high and low register selects differ.
	assign two_word = (instr_ff.fld[3:2] != instr_ff.fld[1:0]);

	// Conditional test reads the flags only; nothing here writes them.
	always_comb
	begin
		take_jump = 1'b0;
		if (instr_ff.fld >= 4'h8)
			take_jump = sense_ff[instr_ff.fld[2:0]];
		else if (instr_ff.fld >= `BSSE_FLD_PC && instr_ff.fld <= `BSSE_FLD_SIGN_HI)
			take_jump = ~ar_ff[instr_ff.fld[1:0] - 2'h1][`BSSE_SIGN_BIT];
		else if (instr_ff.fld == `BSSE_FLD_LOW)
			take_jump = cmp_ind[0];
		else if (instr_ff.fld == `BSSE_FLD_EQUAL)
			take_jump = cmp_ind[1];
		else if (instr_ff.fld == `BSSE_FLD_HIGH)
			take_jump = cmp_ind[2];
	end

	// Execution time of the instruction in the execute state.
	always_comb
	begin
		nxt_cnt = `BSSE_CYC_JUMP;
		unique case (instr_ff.op)
			`BSSE_OP_JUMP:   nxt_cnt = `BSSE_CYC_JUMP;
			`BSSE_OP_JSAVE:  nxt_cnt = `BSSE_CYC_JSAVE;
			`BSSE_OP_FSET:   nxt_cnt = `BSSE_CYC_FLAG;
			`BSSE_OP_FCLR:   nxt_cnt = `BSSE_CYC_FLAG;
			`BSSE_OP_BRANCH: nxt_cnt = take_jump ? `BSSE_CYC_TAKEN : `BSSE_CYC_NOTAKEN;
			`BSSE_OP_SHR:
				if (two_word && !(ea_ff >= `BSSE_LONG_LO && ea_ff <= `BSSE_LONG_HI))
					nxt_cnt = `BSSE_CYC_SHR2;
				else
					nxt_cnt = `BSSE_CYC_SHR1;
			`BSSE_OP_SHL:
				if (two_word && !(ea_ff >= `BSSE_LONG_LO && ea_ff <= `BSSE_LONG_HI))
					nxt_cnt = `BSSE_CYC_SHL2;
				else
					nxt_cnt = `BSSE_CYC_SHL1;
			default:         nxt_cnt = `BSSE_CYC_JUMP;
		endcase
	end

	// Counter reading to be saved by the jump-and-save instruction.
	always_comb
	begin
		if (instr_ff.fld == `BSSE_FLD_PC)
			save_val = program_counter_ff + 15'h0001;
		else if (instr_ff.fld == `BSSE_FLD_MAR)
			save_val = mar_ff + 15'h0001;
		else if (instr_ff.fld >= `BSSE_FLD_CH_LO)
			save_val = channel_address_counter[instr_ff.fld - `BSSE_FLD_CH_LO] + 15'h0001;
		else
			save_val = program_counter_ff + 15'h0001;
	end

	// ------------------------------------------------------------------------
	// Shift datapath.
	// ------------------------------------------------------------------------
	// Digits only; the sign bits never enter the shifter.
	assign operand = {two_word ? ar_ff[instr_ff.fld[3:2]][23:0] : {6{`BSSE_DIGIT_FILL}},
		ar_ff[instr_ff.fld[1:0]][23:0]};

	// Bad digit codes are cleaned before the shift.
	bsse_digit_fix u_fix (
		.digits_in  (operand),
		.digits_out (fixed)
	);

	assign shifted = dshift(fixed, ea_ff, instr_ff.op == `BSSE_OP_SHL, two_word);

	// ------------------------------------------------------------------------
	// Sequencer.
	// ------------------------------------------------------------------------
	assign done = (state_ff == S_EXEC) && (cnt_ff == 4'h1) && (instr_ff.op != `BSSE_OP_JSAVE);

	// Moves an accepted instruction through address, indirection and execution.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= S_IDLE;
			instr_ff <= '0;
			ea_ff    <= 15'h0000;
			cnt_ff   <= 4'h0;
		end
		else if (ce)
		begin
			unique case (state_ff)
				S_IDLE:
					if (wr_fire && awaddr_ff == `BSSE_OFF_INSTR)
					begin
						instr_ff <= wdata_ff[24:0];
						state_ff <= S_ADDR;
					end
				S_ADDR:
				begin
					ea_ff <= nxt_ea;
					// Set and clear never go indirect.
					if (instr_ff.ind && instr_ff.op != `BSSE_OP_FSET
						&& instr_ff.op != `BSSE_OP_FCLR)
						state_ff <= S_IND;
					else
						state_ff <= S_EXEC;
				end
				S_IND:
					if (mem_rsp.ready)
					begin
						ea_ff    <= mem_rsp.rdata[14:0];
						state_ff <= S_EXEC;
					end
				S_EXEC:
					if (cnt_ff == 4'h0)
						cnt_ff <= nxt_cnt;
					else if (cnt_ff == 4'h1)
					begin
						cnt_ff   <= 4'h0;
						state_ff <= (instr_ff.op == `BSSE_OP_JSAVE) ? S_STORE : S_IDLE;
					end
					else
						cnt_ff <= cnt_ff - 4'h1;
				S_STORE:
					if (mem_rsp.ready)
						state_ff <= S_IDLE;
				default:
					state_ff <= S_IDLE;
			endcase
		end
	end

	// Memory request for indirection and for the saved counter word.
	always_comb
	begin
		mem_req       = '0;
		mem_req.addr  = ea_ff;
		if (state_ff == S_IND)
			mem_req.valid = 1'b1;
		if (state_ff == S_STORE)
		begin
			mem_req.valid = 1'b1;
			mem_req.we    = 1'b1;
			mem_req.wdata = {10'h000, save_val};
		end
	end

	// ------------------------------------------------------------------------
	// Program state.
	// ------------------------------------------------------------------------
	// Program counter: software writes when idle, instructions update it.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			program_counter_ff <= 15'h0000;
		else if (ce)
		begin
			if (state_ff == S_STORE && mem_rsp.ready)
				program_counter_ff <= ea_ff + 15'h0001;
			else if (done && instr_ff.op == `BSSE_OP_JUMP)
				program_counter_ff <= ea_ff;
			else if (done && instr_ff.op == `BSSE_OP_BRANCH)
				program_counter_ff <= take_jump ? ea_ff : program_counter_ff + 15'h0001;
			else if (!busy && wr_fire && awaddr_ff == `BSSE_OFF_PC)
				program_counter_ff <= wdata_ff[14:0];
		end
	end

	// Sense indicators; a repeat set or clear simply rewrites the same value.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sense_ff <= 8'h00;
		else if (ce && done && instr_ff.fld[3])
		begin
			if (instr_ff.op == `BSSE_OP_FSET)
				sense_ff[instr_ff.fld[2:0]] <= 1'b1;
			else if (instr_ff.op == `BSSE_OP_FCLR)
				sense_ff[instr_ff.fld[2:0]] <= 1'b0;
		end
	end

	// Arithmetic registers: shift results land only in the selected ones.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
				ar_ff[i] <= 25'h0000000;
		end
		else if (ce)
		begin
			if (done && (instr_ff.op == `BSSE_OP_SHR || instr_ff.op == `BSSE_OP_SHL))
			begin
				ar_ff[instr_ff.fld[1:0]][23:0] <= shifted[23:0];
				if (two_word)
					ar_ff[instr_ff.fld[3:2]][23:0] <= shifted[47:24];
			end
			else if (!busy && wr_fire && awaddr_ff >= `BSSE_OFF_AR1
				&& awaddr_ff <= `BSSE_OFF_AR4 && awaddr_ff[1:0] == 2'h0)
				ar_ff[awaddr_ff[3:2]] <= 25'(strb_merge(32'(ar_ff[awaddr_ff[3:2]]),
					wdata_ff, wstrb_ff));
		end
	end

	// Memory-address register and the status bits of the last instruction.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mar_ff   <= 15'h0000;
			sherr_ff <= 1'b0;
			illop_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (!busy && wr_fire && awaddr_ff == `BSSE_OFF_MAR)
				mar_ff <= 15'(strb_merge(32'(mar_ff), wdata_ff, wstrb_ff));
			if (state_ff == S_ADDR)
			begin
				sherr_ff <= 1'b0;
				illop_ff <= 1'b0;
			end
			else if (done)
			begin
				// A count beyond the operand empties it; flag it for software.
				sherr_ff <= (instr_ff.op == `BSSE_OP_SHR || instr_ff.op == `BSSE_OP_SHL)
					&& (ea_ff > (two_word ? 15'd12 : 15'd6));
				illop_ff <= !(instr_ff.op inside {`BSSE_OP_JUMP, `BSSE_OP_BRANCH,
					`BSSE_OP_FSET, `BSSE_OP_FCLR, `BSSE_OP_SHR, `BSSE_OP_SHL});
			end
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite write channel.
	// ------------------------------------------------------------------------
	assign s_axi_awready = ce && !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = ce && !w_have_ff && !bvalid_ff;
	assign wr_fire       = aw_have_ff && w_have_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// Address and data are caught in either order, then answered together.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `BSSE_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= (awaddr_ff <= `BSSE_OFF_AR4 && awaddr_ff[1:0] == 2'h0
					&& awaddr_ff != `BSSE_OFF_STATUS) ? `BSSE_RESP_OKAY : `BSSE_RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite read channel.
	// ------------------------------------------------------------------------
	assign s_axi_arready = ce && !rvalid_ff;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// Registered read answer one cycle after the address is taken.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= `BSSE_RESP_OKAY;
		end
		else if (ce)
		begin
			if (rd_fire)
			begin
				rvalid_ff <= 1'b1;
				rresp_ff  <= `BSSE_RESP_OKAY;
				rdata_ff  <= 32'h00000000;
				if (s_axi_araddr == `BSSE_OFF_INSTR)
					rdata_ff <= {7'h00, instr_ff};
				else if (s_axi_araddr == `BSSE_OFF_STATUS)
					rdata_ff <= {16'h0000, sense_ff, 5'h00, illop_ff, sherr_ff, busy};
				else if (s_axi_araddr == `BSSE_OFF_PC)
					rdata_ff <= {17'h00000, program_counter_ff};
				else if (s_axi_araddr == `BSSE_OFF_MAR)
					rdata_ff <= {17'h00000, mar_ff};
				else if (s_axi_araddr >= `BSSE_OFF_AR1 && s_axi_araddr <= `BSSE_OFF_AR4
					&& s_axi_araddr[1:0] == 2'h0)
					rdata_ff <= {7'h00, ar_ff[s_axi_araddr[3:2]]};
				else
					rresp_ff <= `BSSE_RESP_SLVERR;
			end
			else if (rvalid_ff && s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

endmodule // bsse_exec

// ===== verification/bsse_exec_properties.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Handshake and store checks on the executor's ports.
// ----------------------------------------------------------------------------
module bsse_exec_props
	import bsse_pkg::*;
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	input  wire logic          s_axi_awvalid,
	input  wire logic          s_axi_awready,
	input  wire logic          s_axi_wvalid,
	input  wire logic          s_axi_wready,
	input  wire logic          s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic          s_axi_arvalid,
	input  wire logic          s_axi_arready,
	input  wire logic [31:0]   s_axi_rdata,
	input  wire logic          s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire bsse_mem_req_t mem_req,
	input  wire bsse_mem_rsp_t mem_rsp
);
	// One clock, one reset.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed before it was taken");
	chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two edges later");
	chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while a response is pending");
	chk_ce_gate: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready high while clock enable is low");
	chk_mem_hold: assert property (mem_req.valid && !mem_rsp.ready |=> mem_req.valid && $stable(mem_req))
		else $error("memory request changed before completion");
	chk_store_top: assert property (mem_req.valid && mem_req.we |-> mem_req.wdata[24:15] == 10'h000)
		else $error("stored word has upper bits set");
endmodule // bsse_exec_props

bind bsse_exec bsse_exec_props chk (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_rsp);

// ===== verification/bsse_mem_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Core memory: completes each access after lat wait cycles.
// ----------------------------------------------------------------------------
module bsse_mem_model
	import bsse_pkg::*;
(
	input  wire logic          aclk,
	input  wire logic [1:0]    lat,
	input  wire bsse_mem_req_t mem_req,
	output bsse_mem_rsp_t      mem_rsp
);
	logic [24:0] mem [0:31];
	logic [1:0]  wait_ff = 2'h0;
	logic [24:0] junk_ff = 25'h0aaaaaa;

	// Counts wait cycles and stores writes.
	always_ff @(posedge aclk)
	begin
		junk_ff <= ~junk_ff;
		wait_ff <= (!mem_req.valid || mem_rsp.ready) ? 2'h0 : wait_ff + 2'h1;
		if (mem_req.valid && mem_rsp.ready && mem_req.we)
			mem[mem_req.addr[4:0]] <= mem_req.wdata;
	end

	// Read data is junk unless ready.
	assign mem_rsp.ready = mem_req.valid && wait_ff == lat;
	assign mem_rsp.rdata = mem_rsp.ready ? mem[mem_req.addr[4:0]] : junk_ff;
endmodule // bsse_mem_model

// ===== verification/bsse_exec_tb_top.sv
`timescale 1ns/10ps
`include "bsse_map.svh"

module branch_sense_shift_exec_tb_top
	import bsse_pkg::*;
;
	logic          aclk = 1'b0, aresetn = 1'b0, ce = 1'b0;
	logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic          s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]    s_axi_wstrb = 4'hf, idx_sel;
	logic [1:0]    s_axi_bresp, s_axi_rresp, r, lat = 2'h0;
	logic [14:0]   idx_val;
	logic [2:0]    cmp_ind = 3'h2;
	bsse_chan_t    channel_address_counter;
	bsse_mem_req_t mem_req;
	bsse_mem_rsp_t mem_rsp;
	int            fails = 0, tests_run = 0, cyc = 0, tj, ts, tx, pce;

	// Makes the 50 MHz clock.
	always #10 aclk = ~aclk;

	// Index register k reads 0x500 plus k.
	assign idx_val = {7'h05, 4'h0, idx_sel};

	// Channel counter k reads 0x200 plus k.
	always_comb
		for (int k = 0; k < 13; k++)
			channel_address_counter[k] = 15'h0200 + 15'(k);

	bsse_exec uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idx_sel, .idx_val,
		.channel_address_counter, .cmp_ind, .mem_req, .mem_rsp);
	bsse_mem_model mdl (.aclk, .lat, .mem_req, .mem_rsp);

	// Counts cycles and cuts a hung run short.
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fails++;
			summarize();
		end
	end

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus write.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, {30'h0, e});
	endtask

	// One bus read.
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			d = s_axi_rdata;
			r = s_axi_rresp;
		end
		while (!s_axi_rvalid);
	endtask

	// Checks a read value and an OKAY response.
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
		chk({30'h0, r}, {30'h0, `BSSE_RESP_OKAY});
	endtask

	// Runs an instruction to idle and returns its cycle count.
	task automatic run(input logic [24:0] i, output int t);
		wr(`BSSE_OFF_INSTR, {7'h0, i}, `BSSE_RESP_OKAY);
		t = cyc;
		do
			rd(`BSSE_OFF_STATUS);
		while (d[0] !== 1'b0);
		t = cyc - t;
	endtask

	// Builds an instruction word.
	function automatic logic [24:0] mk(logic [5:0] o, logic [3:0] f, logic [9:0] a,
		logic [3:0] x = 4'h0, logic i = 1'b0);
		return {i, x, o, f, a};
	endfunction

	// Prints the verdict and ends the run.
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Test sequence.
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		ce <= 1'b1;
		rc(`BSSE_OFF_STATUS, 32'h0);
		rc(`BSSE_OFF_PC, 32'h0);
		rd(8'h20);
		chk({30'h0, r}, {30'h0, `BSSE_RESP_SLVERR});
		wr(`BSSE_OFF_STATUS, 32'h1, `BSSE_RESP_SLVERR);
		$display("test reset done");
		run(mk(`BSSE_OP_JUMP, 4'hf, 10'h055), tj);
		rc(`BSSE_OFF_PC, 32'h55);
		mdl.mem[5] = 25'h0123;
		lat <= 2'h2;
		run(mk(`BSSE_OP_JUMP, 4'h0, 10'h004, 4'h1, 1'b1), tx);
		rc(`BSSE_OFF_PC, 32'h123);
		lat <= 2'h0;
		mdl.mem[8] = 25'h1ffffff;
		run(mk(`BSSE_OP_JSAVE, `BSSE_FLD_PC, 10'h008), tx);
		chk({7'h0, mdl.mem[8]}, 32'h124);
		rc(`BSSE_OFF_PC, 32'h9);
		chk(32'(tx > tj), 32'h1);
		wr(`BSSE_OFF_MAR, 32'h777, `BSSE_RESP_OKAY);
		run(mk(`BSSE_OP_JSAVE, `BSSE_FLD_MAR, 10'h009), tx);
		chk({7'h0, mdl.mem[9]}, 32'h778);
		for (int k = 0; k < 13; k++)
		begin
			run(mk(`BSSE_OP_JSAVE, 4'h3 + 4'(k), 10'h010 + 10'(k)), tx);
			chk({7'h0, mdl.mem[16 + k]}, 32'h201 + 32'(k));
		end
		rc(`BSSE_OFF_PC, 32'h1d);
		$display("test transfers done");
		for (int f = 0; f < 8; f++)
		begin
			repeat (2) run(mk(`BSSE_OP_FSET, 4'h8 + 4'(f), 10'h3ff, 4'hf), tx);
			rc(`BSSE_OFF_STATUS, 32'h100 << f);
			run(mk(`BSSE_OP_BRANCH, 4'h8 + 4'(f), 10'h040 + 10'(f)), tx);
			rc(`BSSE_OFF_PC, 32'h40 + 32'(f));
			rc(`BSSE_OFF_STATUS, 32'h100 << f);
			repeat (2) run(mk(`BSSE_OP_FCLR, 4'h8 + 4'(f), 10'h3ff, 4'hf), tx);
			rc(`BSSE_OFF_STATUS, 32'h0);
			run(mk(`BSSE_OP_BRANCH, 4'h8 + 4'(f), 10'h3ff), tx);
			rc(`BSSE_OFF_PC, 32'h41 + 32'(f));
		end
		$display("test sense done");
		wr(`BSSE_OFF_PC, 32'h100, `BSSE_RESP_OKAY);
		pce = 'h100;
		for (int k = 0; k < 4; k++)
		begin
			wr(`BSSE_OFF_AR1 + 8'(4 * k), {7'h0, k[0], 24'h456789}, `BSSE_RESP_OKAY);
			run(mk(`BSSE_OP_BRANCH, 4'h1 + 4'(k), 10'h060), tx);
			pce = k[0] ? pce + 1 : 'h60;
			rc(`BSSE_OFF_PC, 32'(pce));
		end
		$display("test sign done");
		run(mk(`BSSE_OP_SHR, 4'ha, 10'h002), tx);
		rc(`BSSE_OFF_AR1 + 8'h08, 32'h0334567);
		run(mk(`BSSE_OP_SHL, 4'ha, 10'h001), tx);
		rc(`BSSE_OFF_AR1 + 8'h08, 32'h0345673);
		run(mk(`BSSE_OP_SHR, 4'h4, 10'h008), ts);
		rc(`BSSE_OFF_AR1 + 8'h04, 32'h1333333);
		rc(`BSSE_OFF_AR1, 32'h0334567);
		mdl.mem[6] = 25'h1;
		run(mk(`BSSE_OP_SHR, 4'h4, 10'h006, 4'h0, 1'b1), tx);
		rc(`BSSE_OFF_AR1, 32'h0333456);
		chk(32'(tx > ts), 32'h1);
		run(mk(`BSSE_OP_SHL, 4'he, 10'h000), tj);
		rc(`BSSE_OFF_AR4, 32'h1456789);
		run(mk(`BSSE_OP_SHL, 4'he, 10'h008), ts);
		rc(`BSSE_OFF_AR4, 32'h1567333);
		chk(32'(tj > ts), 32'h1);
		run(mk(`BSSE_OP_SHL, 4'he, 10'h00d), tx);
		rc(`BSSE_OFF_AR1 + 8'h08, 32'h0333333);
		rc(`BSSE_OFF_STATUS, 32'h2);
		rc(`BSSE_OFF_AR1 + 8'h04, 32'h1333333);
		$display("test shifts done");
		summarize();
	end
endmodule // branch_sense_shift_exec_tb_top
